// File: spt_chk_checker.sv
// port checker for the lane self-test block
`timescale 1ns/1ps
`include "spt_defs.vh"
module spt_chk
#(
	parameter PRESC_DIV = `SPT_PRESC_DIV
)
(
	input wire clk_i,
	input wire nrst_i,
	input wire [11:0] addr_i,
	input wire [31:0] wdata_i,
	input wire we_i,
	input wire re_i,
	input wire [31:0] rdata_o,
	input wire [1:0] sts_slf_sel_i,
	input wire [2:0] sts_eq_i,
	input wire sts_align_i,
	input wire sts_half_i,
	input wire loss_raw_i,
	input wire [1:0] signal_loss_filter_sel_o,
	input wire [2:0] receive_equalizer_setting_o,
	input wire rx_align_en_o,
	input wire rx_half_rate_o,
	input wire signal_loss_flag_o,
	input wire [9:0] tx_word_o
);
	reg [13:0] gen_r;
	reg [14:0] ovr_r;
	reg [2:0] up_r;
	reg [15:0] lcnt_r;
	wire gwe = we_i && addr_i == `SPT_OFS_GEN;
	wire map = addr_i == `SPT_OFS_GEN || addr_i == `SPT_OFS_OVR ||
		addr_i == `SPT_OFS_PM;
	wire [6:0] ctl = {signal_loss_filter_sel_o, receive_equalizer_setting_o,
		rx_align_en_o, rx_half_rate_o};
	wire [6:0] ovc = {ovr_r[13:12], ovr_r[7:5], ovr_r[3], ovr_r[0]};
	wire [6:0] stc = {sts_slf_sel_i, sts_eq_i, sts_align_i, sts_half_i};
	wire ovr_en = ovr_r[14];
	wire [2:0] gm = gen_r[2:0];
	wire trg = gen_r[3];
	wire [9:0] gwd = gen_r[13:4];
	// ====================================================
	// shadow of the generator and override fields, plus the reset-release and loss-run counters
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			gen_r <= 14'h0000;
			ovr_r <= 15'h101e;
			up_r <= 3'h0;
			lcnt_r <= 16'h0000;
		end
		else
		begin
			if (gwe)
				gen_r <= wdata_i[29:16];
			if (we_i && addr_i == `SPT_OFS_OVR)
				ovr_r <= wdata_i[14:0];
			if (up_r != 3'h4)
				up_r <= up_r + 3'h1;
			if (!loss_raw_i)
				lcnt_r <= 16'h0000;
			else if (lcnt_r != 16'hffff)
				lcnt_r <= lcnt_r + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ====================================================
	// assertions
	AST_STS: assert property (
		up_r == 3'h4 && !$past(ovr_en) |-> ctl == $past(stc))
		else $error("controls do not follow status inputs");
	AST_OVR: assert property (
		$past(ovr_en) |-> ctl == $past(ovc))
		else $error("controls do not follow override fields");
	AST_RDOVR: assert property (
		$past(re_i) && $past(addr_i) == `SPT_OFS_OVR |->
		rdata_o == {17'h0_0000, $past(ovr_r)})
		else $error("override read back wrong");
	AST_IDLE: assert property (
		!$past(re_i) || !$past(map) |-> rdata_o == 32'h0000_0000)
		else $error("read data outside its slot");
	AST_FIX: assert property (
		$past(gm) == `SPT_MODE_FIX && !$past(trg) |-> tx_word_o == $past(gwd))
		else $error("fixed word wrong");
	AST_DCB: assert property (
		$past(gm) == `SPT_MODE_DCB && !$past(trg) && !$past(gwe) &&
		!$past(gwe, 2) |-> tx_word_o == ~$past(tx_word_o))
		else $error("balanced word does not alternate");
	AST_SEQ: assert property (
		gwe && wdata_i[18:16] == `SPT_MODE_SEQ && !wdata_i[19] |->
		##2 tx_word_o == 10'h000 ##1 tx_word_o == gwd
		##1 tx_word_o == `SPT_ONES ##1 tx_word_o == ~gwd)
		else $error("four word sequence wrong");
	AST_OFF: assert property (
		($past(gm) == 3'h0 || $past(gm) > 3'h5) && !$past(trg) |->
		tx_word_o == 10'h000)
		else $error("disabled generator not quiet");
	AST_TRG: assert property (
		gwe && wdata_i[19] && !trg && wdata_i[18:16] == `SPT_MODE_FIX |->
		##2 tx_word_o == (gwd ^ 10'h001) ##1 tx_word_o == gwd)
		else $error("injected error not single");
	AST_HEAVY: assert property (
		$rose(signal_loss_flag_o) && signal_loss_filter_sel_o ==
		`SPT_SLF_HEAVY |-> lcnt_r >= 123 * PRESC_DIV)
		else $error("heavy loss flag too early");
endmodule

// File: spt_defs.vh
// register map, field positions, reset values and counts of the test block
`ifndef SPT_DEFS_VH
`define SPT_DEFS_VH

// ====================================================
// register offsets
`define SPT_OFS_GEN 12'h000
`define SPT_OFS_OVR 12'h008
`define SPT_OFS_PM 12'h02c

// ====================================================
// receive override register fields
`define SPT_OVR_EN_BIT 14
`define SPT_SLF_HI 13
`define SPT_SLF_LO 12
`define SPT_KEEP_A_HI 11
`define SPT_KEEP_A_LO 8
`define SPT_EQ_HI 7
`define SPT_EQ_LO 5
`define SPT_KEEP_B_BIT 4
`define SPT_ALIGN_BIT 3
`define SPT_KEEP_C_HI 2
`define SPT_KEEP_C_LO 1
`define SPT_HALF_BIT 0
`define SPT_SLF_RST 2'h1
`define SPT_EQ_RST 3'h0
`define SPT_ALIGN_RST 1'h1
`define SPT_HALF_RST 1'h0
`define SPT_KEEP_A_RST 4'h0
`define SPT_KEEP_B_RST 1'h1
`define SPT_KEEP_C_RST 2'h3
`define SPT_SLF_OFF 2'h0
`define SPT_SLF_HEAVY 2'h3

// ====================================================
// generator register fields and modes
`define SPT_PAT_HI 29
`define SPT_PAT_LO 20
`define SPT_TRIG_BIT 19
`define SPT_GMODE_HI 18
`define SPT_GMODE_LO 16
`define SPT_PAT_RST 10'h000
`define SPT_MODE_OFF 3'h0
`define SPT_MODE_L15 3'h1
`define SPT_MODE_L7 3'h2
`define SPT_MODE_FIX 3'h3
`define SPT_MODE_DCB 3'h4
`define SPT_MODE_SEQ 3'h5
`define SPT_ONES 10'h3ff
`define SPT_LFSR_SEED 15'h7fff

// ====================================================
// matcher register fields and counter limits
`define SPT_RNG_BIT 31
`define SPT_CNT_HI 30
`define SPT_CNT_LO 16
`define SPT_SYNC_BIT 3
`define SPT_MMODE_HI 2
`define SPT_MMODE_LO 0
`define SPT_CNT_MAX 15'h7fff
`define SPT_RNG_SHIFT 7

// ====================================================
// signal loss filter
`define SPT_HEAVY_CNT 8'h80
`define SPT_PRESC_DIV 8

`endif

// File: spt_lane_model.sv
// far side of the lane: a loopback with one word of line delay
`timescale 1ns/1ps
module spt_lane_model
(
	input wire clk_i,
	input wire [9:0] tx_i,
	input wire [9:0] flip_i,
	output reg [9:0] rx_o = 10'h000
);
	// flip_i corrupts the returned word only when the bench commands it
	always @(posedge clk_i)
		rx_o <= tx_i ^ flip_i;
endmodule

// File: spt_lfsr_word.v
// one 10-bit word of LFSR steps, free running or seeded from data
`timescale 1ns/1ps
module spt_lfsr_word
(
	input wire [14:0] state_i,
	input wire long_i,
	input wire seed_i,
	input wire [9:0] din_i,
	output reg [14:0] state_o,
	output reg [9:0] word_o
);

reg [14:0] s;
reg fb;
integer i;

// ====================================================
// step loop: bit 0 of the word goes first on the line
always @*
begin
	s = state_i;
	fb = 1'b0;
	word_o = 10'h000;
	for (i = 0; i < 10; i = i + 1)
	begin
		fb = long_i ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
		word_o[i] = fb;
		// seeding shifts in received bits so the register ends up
		// holding the last bits seen, ready to predict the next ones
		s = {s[13:0], (seed_i ? din_i[i] : fb)};
		if (!long_i)
			s[14:7] = 8'h00;
	end
	state_o = s;
end

endmodule

// File: spt_loss_filter.v
// signal loss filter running on the prescaler tick
`timescale 1ns/1ps
`include "spt_defs.vh"
module spt_loss_filter
(
	input wire clk_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire loss_i,
	input wire [1:0] sel_i,
	output reg flag_o
);

reg [7:0] cnt_r;
wire [7:0] cnt_nxt;

assign cnt_nxt = (cnt_r == `SPT_HEAVY_CNT) ? cnt_r : cnt_r + 8'h01;

// ====================================================
// heavy mode needs a full run of lost ticks; any signal resets it
always @(posedge clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		cnt_r <= 8'h00;
		flag_o <= 1'b0;
	end
	else if (tick_i)
	begin
		if (sel_i == `SPT_SLF_HEAVY && loss_i)
		begin
			cnt_r <= cnt_nxt;
			flag_o <= (cnt_nxt == `SPT_HEAVY_CNT);
		end
		else if (sel_i == `SPT_SLF_HEAVY)
		begin
			cnt_r <= 8'h00;
			flag_o <= 1'b0;
		end
		else
		begin
			// off and the reserved codes pass the level unfiltered
			cnt_r <= 8'h00;
			flag_o <= loss_i;
		end
	end
end

endmodule

// File: spt_top.v
// lane self-test: receive override, pattern generator and matcher
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "spt_defs.vh"
//Contract
// - override enable set: receive controls come from override bits 13:0.
// - filter select 00 off, 11 heavy, others reserved; resets to 01.
// - heavy filter flags loss after about 128 prescaler ticks of no signal.
// - three-bit equalizer setting passed on under override; resets to 000.
// - word alignment enable: 0 framer off, 1 on; resets to 1.
// - bit 0 gives half-rate control under override; resets to 0.
// - generator mode 0 off, 1 LFSR15, 2 LFSR7; 6 and 7 reserved.
// - mode 3 repeats the programmed 10-bit word unchanged.
// - mode 4 alternates the word and its complement.
// - mode 5 repeats zeros, word, all ones, complement of word.
// - 10-bit generator word in bits 29:20 feeds modes 3 to 5.
// - trigger bit flips the stream LSB exactly once.
// - matcher mode 0 off, 1 LFSR15, 2 LFSR7, 3 repeat, 4 invert.
// - sync set seeds matcher from data; checking starts after it clears.
// - 15-bit error count; with range flag each unit is 128 errors.
// - range flag set and count at maximum signals overflow.
// - counter reads pipelined; second read of a pair clears counter.
// - reset returns word, trigger, sync and both modes to defaults.
module spt_top
#(
	parameter PRESC_DIV = `SPT_PRESC_DIV
)
(
	input wire clk_i,
	input wire nrst_i,
	input wire [11:0] addr_i,
	input wire [31:0] wdata_i,
	input wire we_i,
	input wire re_i,
	output reg [31:0] rdata_o,
	input wire [1:0] sts_slf_sel_i,
	input wire [2:0] sts_eq_i,
	input wire sts_align_i,
	input wire sts_half_i,
	input wire loss_raw_i,
	input wire [9:0] rx_word_i,
	output reg [1:0] signal_loss_filter_sel_o,
	output reg [2:0] receive_equalizer_setting_o,
	output reg rx_align_en_o,
	output reg rx_half_rate_o,
	output wire signal_loss_flag_o,
	output reg [9:0] tx_word_o,
	output reg cnt_overflow_o
);

// ====================================================
// reset release and pin synchroniser
reg rst_s1_r;
reg rst_n;
reg loss_s1_r;
reg loss_s2_r;

always @(posedge clk_i or negedge nrst_i)
begin
	if (!nrst_i)
	begin
		rst_s1_r <= 1'b0;
		rst_n <= 1'b0;
	end
	else
	begin
		rst_s1_r <= 1'b1;
		rst_n <= rst_s1_r;
	end
end

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		loss_s1_r <= 1'b0;
		loss_s2_r <= 1'b0;
	end
	else
	begin
		loss_s1_r <= loss_raw_i;
		loss_s2_r <= loss_s1_r;
	end
end

// ====================================================
// register decode
wire wr_gen = we_i && (addr_i == `SPT_OFS_GEN);
wire wr_ovr = we_i && (addr_i == `SPT_OFS_OVR);
wire wr_pm = we_i && (addr_i == `SPT_OFS_PM);
wire rd_pm = re_i && (addr_i == `SPT_OFS_PM);

// ====================================================
// receive override register
reg rx_override_enable_r;
reg [1:0] slf_sel_r;
reg [2:0] eq_r;
reg align_r;
reg half_r;
reg [3:0] keep_a_r;
reg keep_b_r;
reg [1:0] keep_c_r;

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		rx_override_enable_r <= 1'b0;
		slf_sel_r <= `SPT_SLF_RST;
		eq_r <= `SPT_EQ_RST;
		align_r <= `SPT_ALIGN_RST;
		half_r <= `SPT_HALF_RST;
		keep_a_r <= `SPT_KEEP_A_RST;
		keep_b_r <= `SPT_KEEP_B_RST;
		keep_c_r <= `SPT_KEEP_C_RST;
	end
	else if (wr_ovr)
	begin
		rx_override_enable_r <= wdata_i[`SPT_OVR_EN_BIT];
		slf_sel_r <= wdata_i[`SPT_SLF_HI:`SPT_SLF_LO];
		eq_r <= wdata_i[`SPT_EQ_HI:`SPT_EQ_LO];
		align_r <= wdata_i[`SPT_ALIGN_BIT];
		half_r <= wdata_i[`SPT_HALF_BIT];
		// preserve fields are stored as written; software keeps them
		keep_a_r <= wdata_i[`SPT_KEEP_A_HI:`SPT_KEEP_A_LO];
		keep_b_r <= wdata_i[`SPT_KEEP_B_BIT];
		keep_c_r <= wdata_i[`SPT_KEEP_C_HI:`SPT_KEEP_C_LO];
	end
end

// controls are registered so the analog side never sees a mux glitch
always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		signal_loss_filter_sel_o <= `SPT_SLF_RST;
		receive_equalizer_setting_o <= `SPT_EQ_RST;
		rx_align_en_o <= `SPT_ALIGN_RST;
		rx_half_rate_o <= `SPT_HALF_RST;
	end
	else if (rx_override_enable_r)
	begin
		signal_loss_filter_sel_o <= slf_sel_r;
		receive_equalizer_setting_o <= eq_r;
		rx_align_en_o <= align_r;
		rx_half_rate_o <= half_r;
	end
	else
	begin
		signal_loss_filter_sel_o <= sts_slf_sel_i;
		receive_equalizer_setting_o <= sts_eq_i;
		rx_align_en_o <= sts_align_i;
		rx_half_rate_o <= sts_half_i;
	end
end

// ====================================================
// prescaler and signal loss filter
reg [7:0] presc_r;
wire presc_tick = (presc_r == PRESC_DIV[7:0] - 8'h01);

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		presc_r <= 8'h00;
	else if (presc_tick)
		presc_r <= 8'h00;
	else
		presc_r <= presc_r + 8'h01;
end

spt_loss_filter u_filter
(
	.clk_i(clk_i),
	.rst_n_i(rst_n),
	.tick_i(presc_tick),
	.loss_i(loss_s2_r),
	.sel_i(signal_loss_filter_sel_o),
	.flag_o(signal_loss_flag_o)
);

// ====================================================
// pattern generator
reg [9:0] generator_word_r;
reg trig_r;
reg [2:0] gmode_r;
reg inject_r;
reg [1:0] seq_r;
reg [14:0] gst_r;
reg [9:0] gword;
wire [14:0] gst_nxt;
wire [9:0] glfsr_word;
wire g_lfsr = (gmode_r == `SPT_MODE_L15) || (gmode_r == `SPT_MODE_L7);

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		generator_word_r <= `SPT_PAT_RST;
		trig_r <= 1'b0;
		gmode_r <= `SPT_MODE_OFF;
	end
	else if (wr_gen)
	begin
		generator_word_r <= wdata_i[`SPT_PAT_HI:`SPT_PAT_LO];
		trig_r <= wdata_i[`SPT_TRIG_BIT];
		gmode_r <= wdata_i[`SPT_GMODE_HI:`SPT_GMODE_LO];
	end
end

// a rising write of the trigger arms one flip; it waits for a live mode
always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		inject_r <= 1'b0;
	else if (wr_gen && wdata_i[`SPT_TRIG_BIT] && !trig_r)
		inject_r <= 1'b1;
	else if (gmode_r != `SPT_MODE_OFF)
		inject_r <= 1'b0;
end

spt_lfsr_word u_gen_lfsr
(
	.state_i(gst_r),
	.long_i(gmode_r == `SPT_MODE_L15),
	.seed_i(1'b0),
	.din_i(10'h000),
	.state_o(gst_nxt),
	.word_o(glfsr_word)
);

always @*
begin
	case (gmode_r)
	`SPT_MODE_L15, `SPT_MODE_L7:
		gword = glfsr_word;
	`SPT_MODE_FIX:
		gword = generator_word_r;
	`SPT_MODE_DCB:
		gword = seq_r[0] ? ~generator_word_r : generator_word_r;
	`SPT_MODE_SEQ:
		case (seq_r)
		2'h0: gword = 10'h000;
		2'h1: gword = generator_word_r;
		2'h2: gword = `SPT_ONES;
		default: gword = ~generator_word_r;
		endcase
	default:
		gword = 10'h000;
	endcase
end

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		gst_r <= `SPT_LFSR_SEED;
		seq_r <= 2'h0;
		tx_word_o <= 10'h000;
	end
	else
	begin
		// an all-zero state would lock the LFSR, so reseed instead
		if (g_lfsr && gst_nxt != 15'h0000)
			gst_r <= gst_nxt;
		else if (g_lfsr)
			gst_r <= `SPT_LFSR_SEED;
		seq_r <= wr_gen ? 2'h0 : seq_r + 2'h1;
		tx_word_o <= gword ^ {9'h000, inject_r && gmode_r != 3'h0};
	end
end

// ====================================================
// pattern matcher control
reg sync_r;
reg [2:0] mmode_r;
reg armed_r;
reg prev_sync_r;
reg [9:0] prev_rx_r;
reg [14:0] mst_r;
wire [14:0] mst_nxt;
wire [9:0] mlfsr_word;
reg [9:0] expect_w;
reg mode_ok;

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		sync_r <= 1'b0;
		mmode_r <= `SPT_MODE_OFF;
	end
	else if (wr_pm)
	begin
		sync_r <= wdata_i[`SPT_SYNC_BIT];
		mmode_r <= wdata_i[`SPT_MMODE_HI:`SPT_MMODE_LO];
	end
end

// checking is armed only by the falling edge of sync
always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		armed_r <= 1'b0;
	else if (sync_r)
		armed_r <= 1'b0;
	else if (wr_pm && wdata_i[`SPT_MMODE_HI:`SPT_MMODE_LO] != mmode_r)
		armed_r <= 1'b0;
	else if (wr_pm && !wdata_i[`SPT_SYNC_BIT] && sync_r == 1'b0)
		armed_r <= armed_r;
	else
		armed_r <= armed_r | prev_sync_r;
end

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		prev_sync_r <= 1'b0;
	else
		prev_sync_r <= sync_r && !armed_r;
end

spt_lfsr_word u_chk_lfsr
(
	.state_i(mst_r),
	.long_i(mmode_r == `SPT_MODE_L15),
	.seed_i(sync_r),
	.din_i(rx_word_i),
	.state_o(mst_nxt),
	.word_o(mlfsr_word)
);

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		mst_r <= `SPT_LFSR_SEED;
		prev_rx_r <= 10'h000;
	end
	else
	begin
		mst_r <= mst_nxt;
		prev_rx_r <= rx_word_i;
	end
end

always @*
begin
	mode_ok = 1'b1;
	case (mmode_r)
	`SPT_MODE_L15, `SPT_MODE_L7:
		expect_w = mlfsr_word;
	`SPT_MODE_FIX:
		expect_w = prev_rx_r;
	`SPT_MODE_DCB:
		expect_w = ~prev_rx_r;
	default:
	begin
		expect_w = rx_word_i;
		mode_ok = 1'b0;
	end
	endcase
end

// ====================================================
// error count with range flag
reg [3:0] errs;
integer k;
always @*
begin
	errs = 4'h0;
	for (k = 0; k < 10; k = k + 1)
		errs = errs + {3'h0, rx_word_i[k] ^ expect_w[k]};
	if (!(mode_ok && armed_r && !sync_r))
		errs = 4'h0;
end

reg [14:0] cnt_r;
reg rng_r;
reg [6:0] sub_r;
reg [14:0] snap_cnt_r;
reg snap_rng_r;
reg pair_r;
wire clr = rd_pm && pair_r;
// a clearing read still keeps this cycle's errors: the set wins
wire [14:0] cnt_b = clr ? 15'h0000 : cnt_r;
wire rng_b = clr ? 1'b0 : rng_r;
wire [6:0] sub_b = clr ? 7'h00 : sub_r;
wire [15:0] sum = {1'b0, cnt_b} + {12'h000, errs};
wire [7:0] sub_sum = {1'b0, sub_b} + {4'h0, errs};

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		cnt_r <= 15'h0000;
		rng_r <= 1'b0;
		sub_r <= 7'h00;
	end
	else if (!rng_b && sum[15])
	begin
		// switch to coarse range, keeping the remainder below a unit
		rng_r <= 1'b1;
		cnt_r <= {6'h00, sum[15:`SPT_RNG_SHIFT]};
		sub_r <= sum[`SPT_RNG_SHIFT-1:0];
	end
	else if (!rng_b)
	begin
		rng_r <= 1'b0;
		cnt_r <= sum[14:0];
		sub_r <= 7'h00;
	end
	else
	begin
		// coarse range saturates at the top instead of wrapping
		rng_r <= 1'b1;
		sub_r <= sub_sum[6:0];
		if (sub_sum[7] && cnt_b != `SPT_CNT_MAX)
			cnt_r <= cnt_b + 15'h0001;
		else
			cnt_r <= cnt_b;
	end
end

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		cnt_overflow_o <= 1'b0;
	else
		cnt_overflow_o <= rng_r && cnt_r == `SPT_CNT_MAX;
end

// ====================================================
// read port: the matcher word returns the snapshot of the last read
always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
	begin
		snap_cnt_r <= 15'h0000;
		snap_rng_r <= 1'b0;
		pair_r <= 1'b0;
	end
	else if (rd_pm)
	begin
		snap_cnt_r <= cnt_r;
		snap_rng_r <= rng_r;
		pair_r <= !pair_r;
	end
end

always @(posedge clk_i or negedge rst_n)
begin
	if (!rst_n)
		rdata_o <= 32'h0000_0000;
	else if (!re_i)
		rdata_o <= 32'h0000_0000;
	else
	begin
		case (addr_i)
		`SPT_OFS_GEN:
			rdata_o <= {2'h0, generator_word_r, trig_r, gmode_r, 16'h0000};
		`SPT_OFS_OVR:
			rdata_o <= {17'h0_0000, rx_override_enable_r, slf_sel_r,
				keep_a_r, eq_r, keep_b_r, align_r, keep_c_r, half_r};
		`SPT_OFS_PM:
			rdata_o <= {snap_rng_r, snap_cnt_r, 12'h000, sync_r,
				mmode_r};
		default:
			rdata_o <= 32'h0000_0000;
		endcase
	end
end

endmodule

// File: spt_top_tb_top.sv
// self-checking bench for the lane self-test block
`timescale 1ns/1ps
`include "spt_defs.vh"
module spt_top_tb_top;
	reg clk_i = 1'b0;
	reg nrst_i = 1'b0;
	reg [11:0] addr = 12'h000;
	reg [31:0] wdat = 32'h0000_0000;
	reg we = 1'b0;
	reg re = 1'b0;
	reg [6:0] stc = 7'h00;
	reg loss = 1'b0;
	reg [9:0] flip = 10'h000;
	wire [9:0] rxw;
	wire [9:0] txw;
	wire [31:0] rdat;
	wire [6:0] ctl;
	wire flag;
	wire ovf;
	integer fails = 0;
	integer compares = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] v;
	spt_top #(.PRESC_DIV(2)) i_dut (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.addr_i(addr),
		.wdata_i(wdat),
		.we_i(we),
		.re_i(re),
		.rdata_o(rdat),
		.sts_slf_sel_i(stc[6:5]),
		.sts_eq_i(stc[4:2]),
		.sts_align_i(stc[1]),
		.sts_half_i(stc[0]),
		.loss_raw_i(loss),
		.rx_word_i(rxw),
		.signal_loss_filter_sel_o(ctl[6:5]),
		.receive_equalizer_setting_o(ctl[4:2]),
		.rx_align_en_o(ctl[1]),
		.rx_half_rate_o(ctl[0]),
		.signal_loss_flag_o(flag),
		.tx_word_o(txw),
		.cnt_overflow_o(ovf)
	);
	spt_lane_model i_lane (
		.clk_i(clk_i),
		.tx_i(txw),
		.flip_i(flip),
		.rx_o(rxw)
	);
	initial
		forever #4 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 8000)
		begin
			fails = fails + 1;
			end_sim;
		end
	end
	// ====================================================
	// bus tasks
	task chk(input [31:0] s, input [31:0] e);
		begin
			compares = compares + 1;
			if (s !== e)
			begin
				fails = fails + 1;
				$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			we <= 1'b1;
			addr <= a;
			wdat <= d;
			@(posedge clk_i);
			we <= 1'b0;
		end
	endtask
	task rd(input [11:0] a);
		begin
			@(posedge clk_i);
			re <= 1'b1;
			addr <= a;
			@(posedge clk_i);
			re <= 1'b0;
			#1;
			v = rdat;
		end
	endtask
	// counter reads always go in pairs so the pipeline stays aligned
	task rdc(input [14:0] e);
		begin
			rd(`SPT_OFS_PM);
			rd(`SPT_OFS_PM);
			chk({17'h0_0000, v[30:16]}, {17'h0_0000, e});
		end
	endtask
	task syn(input [2:0] m);
		begin
			wr(`SPT_OFS_PM, {28'h000_0000, 1'b1, m});
			wr(`SPT_OFS_GEN, {12'h2b5, 1'b0, m, 16'h0000});
			repeat (6) @(posedge clk_i);
			wr(`SPT_OFS_PM, {29'h0000_0000, m});
			repeat (8) @(posedge clk_i);
			rdc(15'h0000);
		end
	endtask
	task end_sim;
		begin
			$display("compares=%0d fails=%0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// ====================================================
	// tests
	initial
	begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(`SPT_OFS_GEN);
		chk(v, 32'h0000_0000);
		rd(`SPT_OFS_PM);
		chk(v, 32'h0000_0000);
		rd(`SPT_OFS_PM);
		rd(12'h004);
		chk(v, 32'h0000_0000);
		rd(`SPT_OFS_OVR);
		chk(v, 32'h0000_101e);
		@(posedge clk_i);
		stc <= 7'h5a;
		repeat (3) @(posedge clk_i);
		#1;
		chk({25'h000_0000, ctl}, 32'h0000_005a);
		wr(`SPT_OFS_OVR, (v & 32'h0000_0f16) | 32'h0000_70a1);
		rd(`SPT_OFS_OVR);
		chk(v, 32'h0000_70b7);
		chk({25'h000_0000, ctl}, 32'h0000_0075);
		@(posedge clk_i);
		loss <= 1'b1;
		repeat (240) @(posedge clk_i);
		chk({31'h0000_0000, flag}, 32'h0000_0000);
		repeat (40) @(posedge clk_i);
		chk({31'h0000_0000, flag}, 32'h0000_0001);
		loss <= 1'b0;
		wr(`SPT_OFS_OVR, 32'h0000_4016);
		repeat (10) @(posedge clk_i);
		loss <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk({31'h0000_0000, flag}, 32'h0000_0001);
		loss <= 1'b0;
		for (i = 1; i <= 4; i = i + 1)
		begin
			syn(i[2:0]);
			@(posedge clk_i);
			flip <= 10'h081;
			@(posedge clk_i);
			flip <= 10'h000;
			repeat (6) @(posedge clk_i);
			rdc((i < 3) ? 15'h0002 : 15'h0004);
			if (i != 4)
			begin
				wr(`SPT_OFS_GEN, {12'h2b5, 1'b1, i[2:0], 16'h0000});
				repeat (6) @(posedge clk_i);
				rdc((i < 3) ? 15'h0001 : 15'h0002);
			end
		end
		// matcher off while the generator leaves the checked pattern
		wr(`SPT_OFS_PM, 32'h0000_0000);
		wr(`SPT_OFS_GEN, {12'h1c6, 1'b0, `SPT_MODE_SEQ, 16'h0000});
		repeat (8) @(posedge clk_i);
		wr(`SPT_OFS_GEN, {12'h1c6, 1'b0, 3'h6, 16'h0000});
		repeat (3) @(posedge clk_i);
		wr(`SPT_OFS_GEN, {12'h1c6, 1'b0, 3'h7, 16'h0000});
		repeat (3) @(posedge clk_i);
		chk({22'h00_0000, txw}, 32'h0000_0000);
		syn(`SPT_MODE_FIX);
		for (i = 0; i < 3400; i = i + 1)
		begin
			@(posedge clk_i);
			flip <= ~flip;
		end
		flip <= 10'h000;
		repeat (4) @(posedge clk_i);
		rd(`SPT_OFS_PM);
		rd(`SPT_OFS_PM);
		chk({31'h0, v[31] && v[30:16] > 255 && v[30:16] < 275}, 1);
		chk({31'h0000_0000, ovf}, 32'h0000_0000);
		rdc(15'h0000);
		end_sim;
	end
endmodule
bind spt_top spt_chk #(.PRESC_DIV(PRESC_DIV)) i_chk (
	.clk_i, .nrst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
	.sts_slf_sel_i, .sts_eq_i, .sts_align_i, .sts_half_i, .loss_raw_i,
	.signal_loss_filter_sel_o, .receive_equalizer_setting_o,
	.rx_align_en_o, .rx_half_rate_o, .signal_loss_flag_o, .tx_word_o
);
